// ==== rtl/cmo_pkg.sv ====
// Package: constants and types for the message object control block
package cmo_pkg;
    localparam int CMO_NUM_OBJ = 8;
    localparam int CMO_PTR_W = 3;
    localparam int CMO_CNT_W = 16;
    localparam int CMO_FIFO_W = 8;
    localparam int CMO_FIFO_DEPTH = 16;
    localparam logic [1:0] CMO_COUNTER_FUNCTION_MODE_TIMING = 2'h2;
    localparam logic [2:0] CMO_SEL_REC_AFTER_DOM = 3'h1;
    localparam logic [2:0] CMO_SEL_DOM_LOOP = 3'h2;
    localparam logic [2:0] CMO_SEL_REC_LOOP = 3'h3;
    localparam logic [2:0] CMO_SEL_SYNC_SP = 3'h4;
    localparam logic [1:0] CMO_KIND_STD = 2'h0;
    localparam logic [1:0] CMO_KIND_TXSLV = 2'h1;
    localparam logic [1:0] CMO_KIND_GWSLV = 2'h2;
    localparam logic [1:0] CMO_KIND_BASE = 2'h3;
    typedef enum logic [1:0] {
        CMO_IDLE,
        CMO_SLAVE,
        CMO_BASE
    } cmo_state_t;
endpackage : cmo_pkg

// ==== rtl/cmo_fifo.sv ====
// Module: parameterised valid/ready FIFO in flip-flops
`timescale 1ns/10ps
`default_nettype none
module cmo_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    logic push;
    logic pop;
    logic rdy_q;

    // Ready is a register so the upstream side never sees a comparator
    assign in_ready = rdy_q;
    assign out_valid = (cnt_q != '0);
    assign out_data = mem_q[rd_q];
    assign push = clk_en && in_valid && in_ready;
    assign pop = clk_en && out_valid && out_ready;

    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
            rdy_q <= 1'b1;
        end else begin
            if (push) begin
                wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + 1'b1;
                rdy_q <= (cnt_q != DEPTH[AW:0] - 1'b1);
            end else if (pop && !push) begin
                cnt_q <= cnt_q - 1'b1;
                rdy_q <= 1'b1;
            end
        end
    end
endmodule : cmo_fifo
`default_nettype wire

// ==== rtl/cmo_top.sv ====
// Module: message object valid/FIFO handling and bit-timing measurement
`timescale 1ns/10ps
`default_nettype none
module cmo_top
    import cmo_pkg::*;
#(
    parameter int NUM_OBJ = CMO_NUM_OBJ,
    parameter int CNT_W = CMO_CNT_W
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic obj_wr,
    input wire logic [CMO_PTR_W-1:0] obj_wr_idx,
    input wire logic obj_wr_valid,
    input wire logic obj_wr_single,
    input wire logic obj_wr_overflow_irq_enable,
    input wire logic obj_wr_redirect,
    input wire logic [1:0] obj_wr_kind,
    input wire logic [CMO_PTR_W-1:0] obj_wr_base,
    input wire logic [CMO_PTR_W-1:0] obj_wr_bottom,
    input wire logic [CMO_PTR_W-1:0] obj_wr_limit,
    input wire logic [CMO_PTR_W-1:0] obj_wr_top,
    input wire logic ev_valid,
    output logic ev_ready,
    input wire logic ev_is_tx,
    input wire logic ev_remote,
    input wire logic [CMO_PTR_W-1:0] ev_idx,
    input wire logic list_object_error,
    input wire logic tx_busy,
    input wire logic tx_req,
    input wire logic [CMO_PTR_W-1:0] tx_req_idx,
    input wire logic tx_done,
    input wire logic tx_fail,
    input wire logic [1:0] counter_function_mode,
    input wire logic [2:0] measurement_select,
    input wire logic can_rx_pin,
    input wire logic can_tx,
    input wire logic sample_point,
    input wire logic sync_enable,
    output logic [NUM_OBJ-1:0] msg_valid,
    output logic [CMO_PTR_W-1:0] current_pointer,
    output logic tx_overflow_irq,
    output logic frame_stored,
    output logic tx_start,
    output logic [CMO_PTR_W-1:0] tx_idx,
    output logic [CNT_W-1:0] frame_counter_value
);
    logic [NUM_OBJ-1:0] valid_q;
    logic [NUM_OBJ-1:0] single_q;
    logic [NUM_OBJ-1:0] overflow_irq_enable_q;
    logic [NUM_OBJ-1:0] redir_q;
    logic [1:0] kind_q [NUM_OBJ];
    logic [CMO_PTR_W-1:0] base_q [NUM_OBJ];
    logic [CMO_PTR_W-1:0] bot_q [NUM_OBJ];
    logic [CMO_PTR_W-1:0] lim_q [NUM_OBJ];
    logic [CMO_PTR_W-1:0] top_q [NUM_OBJ];
    logic [CMO_PTR_W-1:0] cur_q [NUM_OBJ];
    cmo_state_t state_q;
    logic [CMO_PTR_W-1:0] obj_q;
    logic is_tx_q;
    logic irq_q;
    logic stored_q;
    logic f_valid;
    logic f_ready;
    logic [CMO_FIFO_W-1:0] f_data;
    logic [CMO_FIFO_W-1:0] f_in;
    logic [CMO_PTR_W-1:0] f_idx;
    logic f_tx;
    logic f_rem;
    logic f_loe;
    logic [CMO_PTR_W-1:0] b_idx;
    logic [CMO_PTR_W-1:0] b_next;
    logic pend_q;
    logic [CMO_PTR_W-1:0] cptr_q;
    logic start_q;
    logic [CMO_PTR_W-1:0] txi_q;

    // Events queue here while the object engine works on a previous one
    assign f_in = {{(CMO_FIFO_W-CMO_PTR_W-3){1'b0}}, list_object_error,
        ev_remote, ev_is_tx, ev_idx};
    cmo_fifo #(.WIDTH(CMO_FIFO_W), .DEPTH(CMO_FIFO_DEPTH)) u_fifo (
        .clk(clk),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .in_valid(ev_valid),
        .in_ready(ev_ready),
        .in_data(f_in),
        .out_valid(f_valid),
        .out_ready(f_ready),
        .out_data(f_data)
    );
    assign f_idx = f_data[CMO_PTR_W-1:0];
    assign f_tx = f_data[CMO_PTR_W];
    assign f_rem = f_data[CMO_PTR_W+1];
    assign f_loe = f_data[CMO_PTR_W+2];
    assign f_ready = (state_q == CMO_IDLE);
    assign b_idx = base_q[obj_q];
    assign b_next = (cur_q[b_idx] == top_q[b_idx]) ? bot_q[b_idx]
        : cur_q[b_idx] + 1'b1;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_q <= CMO_IDLE;
            obj_q <= '0;
            is_tx_q <= 1'b0;
        end else if (clk_en) begin
            case (state_q)
                CMO_IDLE: begin
                    // A list-object error on a received frame skips filtering: nothing is stored
                    if (f_valid && !(f_loe && !f_tx)) begin
                        obj_q <= f_idx;
                        is_tx_q <= f_tx;
                        state_q <= (kind_q[f_idx] == CMO_KIND_STD ||
                            kind_q[f_idx] == CMO_KIND_BASE) ? CMO_IDLE
                            : CMO_BASE;
                    end
                end
                CMO_BASE: begin
                    state_q <= CMO_IDLE;
                end
                default: begin
                    state_q <= CMO_IDLE;
                end
            endcase
        end
    end

    // Object table, valid clearing and pointer update
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            valid_q <= '0;
            single_q <= '0;
            overflow_irq_enable_q <= '0;
            redir_q <= '0;
            for (int i = 0; i < NUM_OBJ; i++) begin
                kind_q[i] <= CMO_KIND_STD;
                base_q[i] <= '0;
                bot_q[i] <= '0;
                lim_q[i] <= '0;
                top_q[i] <= '0;
                cur_q[i] <= '0;
            end
        end else if (clk_en) begin
            if (obj_wr) begin
                valid_q[obj_wr_idx] <= obj_wr_valid;
                single_q[obj_wr_idx] <= obj_wr_single;
                overflow_irq_enable_q[obj_wr_idx] <= obj_wr_overflow_irq_enable;
                redir_q[obj_wr_idx] <= obj_wr_redirect;
                kind_q[obj_wr_idx] <= obj_wr_kind;
                base_q[obj_wr_idx] <= obj_wr_base;
                bot_q[obj_wr_idx] <= obj_wr_bottom;
                lim_q[obj_wr_idx] <= obj_wr_limit;
                top_q[obj_wr_idx] <= obj_wr_top;
                cur_q[obj_wr_idx] <= obj_wr_bottom;
            end
            if (state_q == CMO_IDLE && f_valid && !(f_loe && !f_tx) &&
                single_q[f_idx]) begin
                valid_q[f_idx] <= 1'b0;
            end
            if (state_q == CMO_BASE) begin
                cur_q[b_idx] <= b_next;
                if (single_q[b_idx] && b_next == lim_q[b_idx]) begin
                    valid_q[b_idx] <= 1'b0;
                end
            end
        end
    end

    // Overflow pulse, stored-frame pulse and last updated base pointer
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            irq_q <= 1'b0;
            stored_q <= 1'b0;
            cptr_q <= '0;
        end else if (clk_en) begin
            cptr_q <= (state_q == CMO_BASE) ? b_next : cptr_q;
            irq_q <= (state_q == CMO_BASE) && is_tx_q &&
                kind_q[obj_q] == CMO_KIND_TXSLV && overflow_irq_enable_q[b_idx] &&
                b_next == lim_q[b_idx];
            stored_q <= (state_q == CMO_IDLE) && f_valid && !f_tx &&
                !f_loe;
        end
    end

    // Transmit scheduler: a failed frame is held and retried first if its object is still valid or redirected
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pend_q <= 1'b0;
            start_q <= 1'b0;
            txi_q <= '0;
        end else if (clk_en) begin
            start_q <= 1'b0;
            if (tx_done) begin
                pend_q <= 1'b0;
            end
            if (!tx_busy && !start_q && !pend_q && tx_req &&
                (valid_q[tx_req_idx] || redir_q[tx_req_idx])) begin
                start_q <= 1'b1;
                txi_q <= tx_req_idx;
                pend_q <= 1'b1;
            end else if (!tx_busy && !start_q && pend_q && tx_fail) begin
                start_q <= valid_q[txi_q] || redir_q[txi_q];
                pend_q <= valid_q[txi_q] || redir_q[txi_q];
            end
        end
    end

    // Bit-timing measurement
    logic [1:0] rx_sync_q;
    logic rx_q;
    logic tx_q;
    logic [CNT_W-1:0] since_dom_q;
    logic [CNT_W-1:0] since_sp_q;
    logic [CNT_W-1:0] since_tx_q;
    logic [CNT_W-1:0] fcv_q;
    logic mmode;
    logic rx_fall;
    logic rx_rise;
    logic tx_fall;
    logic tx_rise;

    assign mmode = (counter_function_mode == CMO_COUNTER_FUNCTION_MODE_TIMING);
    assign rx_fall = rx_q && !rx_sync_q[1];
    assign rx_rise = !rx_q && rx_sync_q[1];
    assign tx_fall = tx_q && !can_tx;
    assign tx_rise = !tx_q && can_tx;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rx_sync_q <= 2'h3;
            rx_q <= 1'b1;
            tx_q <= 1'b1;
        end else if (clk_en) begin
            rx_sync_q <= {rx_sync_q[0], can_rx_pin};
            rx_q <= rx_sync_q[1];
            tx_q <= can_tx;
        end
    end

    // Interval counters restart at their reference and saturate
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            since_dom_q <= '0;
            since_sp_q <= '0;
            since_tx_q <= '0;
        end else if (clk_en) begin
            since_dom_q <= rx_fall ? '0 : (&since_dom_q ? since_dom_q
                : since_dom_q + 1'b1);
            since_sp_q <= sample_point ? '0 : (&since_sp_q ? since_sp_q
                : since_sp_q + 1'b1);
            since_tx_q <= (tx_fall || tx_rise) ? '0 : (&since_tx_q ?
                since_tx_q : since_tx_q + 1'b1);
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            fcv_q <= '0;
        end else if (clk_en && mmode) begin
            case (measurement_select)
                CMO_SEL_REC_AFTER_DOM: begin
                    if (rx_rise) fcv_q <= since_dom_q;
                end
                CMO_SEL_DOM_LOOP: begin
                    if (rx_fall && !can_tx) fcv_q <= since_tx_q;
                end
                CMO_SEL_REC_LOOP: begin
                    if (rx_rise && can_tx) fcv_q <= since_tx_q;
                end
                CMO_SEL_SYNC_SP: begin
                    if (rx_fall && sync_enable) fcv_q <= since_sp_q;
                end
                default: ;
            endcase
        end
    end

    assign msg_valid = valid_q;
    assign current_pointer = cptr_q;
    assign tx_overflow_irq = irq_q;
    assign frame_stored = stored_q;
    assign tx_start = start_q;
    assign tx_idx = txi_q;
    assign frame_counter_value = fcv_q;

    single_clear_a: assert property (@(posedge clk) disable iff (sys_rst)
        (clk_en && state_q == CMO_IDLE && f_valid && !f_tx && !f_loe &&
        single_q[f_idx] && !obj_wr) |=> !valid_q[$past(f_idx)])
        else $error("single transfer valid not cleared");
    loe_nostore_a: assert property (@(posedge clk) disable iff (sys_rst)
        (clk_en && f_valid && f_loe && !f_tx) |=> !stored_q)
        else $error("frame stored despite list error");
    mode_sel_a: assert property (@(posedge clk) disable iff (sys_rst)
        (!mmode) |=> $stable(fcv_q))
        else $error("counter changed outside timing mode");
    sat_count_a: assert property (@(posedge clk) disable iff (sys_rst)
        (clk_en && &since_sp_q && !sample_point) |=> &since_sp_q)
        else $error("measurement counter wrapped");
    irq_cond_a: assert property (@(posedge clk) disable iff (sys_rst)
        irq_q |-> $past(state_q) == CMO_BASE)
        else $error("overflow irq without base update");
    base_clear_a: assert property (@(posedge clk) disable iff (sys_rst)
        (clk_en && state_q == CMO_BASE && single_q[b_idx] &&
        b_next == lim_q[b_idx] && !obj_wr) |=> !valid_q[$past(b_idx)])
        else $error("base valid not cleared at limit");
    rec_meas_a: assert property (@(posedge clk) disable iff (sys_rst)
        (clk_en && mmode && measurement_select == CMO_SEL_REC_AFTER_DOM &&
        rx_rise) |=> fcv_q == $past(since_dom_q))
        else $error("recessive interval not captured");
    sp_meas_a: assert property (@(posedge clk) disable iff (sys_rst)
        (clk_en && mmode && measurement_select == CMO_SEL_SYNC_SP &&
        rx_fall && sync_enable) |=> fcv_q == $past(since_sp_q))
        else $error("sample point interval not captured");
endmodule : cmo_top
`default_nettype wire

// ==== tb/cmo_can_peer.sv ====
// Other nodes on the shared bus: echo of our own bits plus a foreign dominant
`timescale 1ns/10ps
`default_nettype none
module cmo_can_peer #(
    parameter int LOOP_D = 5
) (
    input wire logic clk,
    input wire logic can_tx,
    input wire logic other_dom,
    output logic can_rx_pin
);
    logic [LOOP_D-1:0] dly_q = '1;

    // Transceiver loop delay seen by our own transmitted bits
    always_ff @(posedge clk) begin
        dly_q <= {dly_q[LOOP_D-2:0], can_tx};
    end

    // Wired-AND bus: a dominant low from any node wins
    assign can_rx_pin = dly_q[LOOP_D-1] & ~other_dom;
endmodule : cmo_can_peer
`default_nettype wire

// ==== tb/test_cmo_top.sv ====
// Self-checking bench for the message object control block
`timescale 1ns/10ps
`default_nettype none
module test_cmo_top
    import cmo_pkg::*;
;
    logic clk = 0, sys_rst = 1, obj_wr = 0, obj_wr_valid = 0;
    logic obj_wr_single = 0, obj_wr_overflow_irq_enable = 0, obj_wr_redirect = 0;
    logic [1:0] obj_wr_kind = 0, counter_function_mode = 0;
    logic [CMO_PTR_W-1:0] obj_wr_idx = 0, obj_wr_base = 0, obj_wr_bottom = 0;
    logic [CMO_PTR_W-1:0] obj_wr_limit = 0, obj_wr_top = 0, ev_idx = 0;
    logic [CMO_PTR_W-1:0] tx_req_idx = 0, tx_idx;
    logic ev_valid = 0, ev_ready, ev_is_tx = 0, ev_remote = 0;
    logic list_object_error = 0, tx_req = 0, tx_done = 0, tx_fail = 0;
    logic clk_en = 1, tx_busy = 0, sync_enable = 1;
    logic [2:0] measurement_select = 0;
    logic can_rx_pin, can_tx = 1, sample_point = 0, other_dom = 0;
    logic [CMO_NUM_OBJ-1:0] msg_valid, exp_v = 0;
    logic [CMO_PTR_W-1:0] current_pointer;
    logic tx_overflow_irq, frame_stored, tx_start;
    logic [CMO_CNT_W-1:0] frame_counter_value;
    logic [7:0] exp_q[$];
    logic [7:0] seed = 8'h53;
    logic [2:0] r;
    int n_errors = 0, tests_run = 0, cyc = 0, n;

    cmo_top DUT (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en),
        .obj_wr(obj_wr), .obj_wr_idx(obj_wr_idx), .obj_wr_valid(obj_wr_valid),
        .obj_wr_single(obj_wr_single), .obj_wr_overflow_irq_enable(obj_wr_overflow_irq_enable),
        .obj_wr_redirect(obj_wr_redirect), .obj_wr_kind(obj_wr_kind),
        .obj_wr_base(obj_wr_base), .obj_wr_bottom(obj_wr_bottom),
        .obj_wr_limit(obj_wr_limit), .obj_wr_top(obj_wr_top),
        .ev_valid(ev_valid), .ev_ready(ev_ready), .ev_is_tx(ev_is_tx),
        .ev_remote(ev_remote), .ev_idx(ev_idx),
        .list_object_error(list_object_error), .tx_busy(tx_busy),
        .tx_req(tx_req), .tx_req_idx(tx_req_idx), .tx_done(tx_done),
        .tx_fail(tx_fail), .counter_function_mode(counter_function_mode),
        .measurement_select(measurement_select), .can_rx_pin(can_rx_pin),
        .can_tx(can_tx), .sample_point(sample_point),
        .sync_enable(sync_enable),
        .msg_valid(msg_valid), .current_pointer(current_pointer),
        .tx_overflow_irq(tx_overflow_irq), .frame_stored(frame_stored),
        .tx_start(tx_start), .tx_idx(tx_idx),
        .frame_counter_value(frame_counter_value));

    cmo_can_peer #(.LOOP_D(5)) peer (.clk(clk), .can_tx(can_tx),
        .other_dom(other_dom), .can_rx_pin(can_rx_pin));

    always #10 clk = ~clk;

    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr

    task automatic bad(input string m);
        n_errors++;
        $display("BAD %0t %s", $time, m);
    endtask : bad

    task automatic chk(input logic ok, input string m);
        tests_run++;
        if (ok !== 1'b1) bad(m);
    endtask : chk

    task automatic close_out();
        $display("compares %0d, mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : close_out

    // Pulsed results are matched in order against the noted expectations
    task automatic note(input logic [7:0] got);
        tests_run++;
        if (exp_q.size() == 0) bad("unexpected pulse");
        else if (exp_q[0] !== got) bad("wrong pulse");
        if (exp_q.size() != 0) exp_q.pop_front();
    endtask : note

    always @(negedge clk) begin
        if (!sys_rst && tx_start === 1'b1) note({5'h02, tx_idx});
        if (!sys_rst && tx_overflow_irq === 1'b1) note(8'h20);
        if (!sys_rst && frame_stored === 1'b1) note(8'h30);
    end

    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_errors++;
            close_out();
        end
    end

    task automatic drain(input int left, input string s);
        for (int i = 0; i < 40 && exp_q.size() > left; i++) @(negedge clk);
        chk(exp_q.size() <= left, "result missing");
        repeat (4) @(negedge clk);
        $display("test %s done", s);
    endtask : drain

    task automatic wr(input logic [2:0] i, input logic v, s, o, rd,
                      input logic [1:0] k, input logic [2:0] b, bo, li, t);
        obj_wr = 1;
        {obj_wr_idx, obj_wr_valid, obj_wr_single, obj_wr_overflow_irq_enable} = {i, v, s, o};
        {obj_wr_redirect, obj_wr_kind, obj_wr_base} = {rd, k, b};
        {obj_wr_bottom, obj_wr_limit, obj_wr_top} = {bo, li, t};
        exp_v[i] = v;
        @(negedge clk);
        obj_wr = 0;
        @(negedge clk);
    endtask : wr

    task automatic ev(input logic tx, rem, input logic [2:0] i,
                      input logic le);
        {ev_valid, ev_is_tx, ev_remote, ev_idx} = {1'b1, tx, rem, i};
        list_object_error = le;
        for (int k = 0; k < 50 && ev_ready !== 1'b1; k++) @(negedge clk);
        @(negedge clk);
        ev_valid = 0;
        list_object_error = 0;
    endtask : ev

    task automatic treq(input logic [2:0] i, input logic fail);
        {tx_req, tx_req_idx, tx_fail} = {1'b1, i, fail};
        @(negedge clk);
        {tx_req, tx_fail} = 2'b00;
    endtask : treq

    initial begin
        repeat (20) @(negedge clk);
        sys_rst = 0;
        // The object table is only rewritten between transfers
        for (int rem = 0; rem < 2; rem++) begin
            seed = lfsr(seed);
            r = seed[2:0] | 3'h1;
            wr(0, 1, 1, 0, 0, CMO_KIND_STD, 0, 0, 0, 0);
            wr(r, 1, 1, 0, 0, CMO_KIND_STD, 0, 0, 0, 0);
            exp_q.push_back(8'h30);
            ev(0, rem[0], r, 0);
            exp_v[r] = 0;
            drain(0, "single");
            chk(msg_valid === exp_v, "std valid");
        end
        wr(1, 1, 1, 0, 0, CMO_KIND_STD, 0, 0, 0, 0);
        ev(0, 0, 1, 1);
        drain(0, "list error");
        chk(msg_valid === exp_v, "stored despite list error");
        clk_en = 0;
        wr(7, 1, 0, 0, 0, CMO_KIND_STD, 0, 0, 0, 0);
        clk_en = 1;
        exp_v[7] = 0;
        chk(msg_valid === exp_v, "write while frozen");
        $display("test freeze done");
        wr(4, 1, 1, 1, 0, CMO_KIND_BASE, 4, 5, 7, 7);
        wr(5, 1, 0, 0, 0, CMO_KIND_TXSLV, 4, 0, 0, 0);
        wr(6, 1, 0, 0, 0, CMO_KIND_TXSLV, 4, 0, 0, 0);
        ev(1, 0, 5, 0);
        drain(0, "fifo first");
        chk(msg_valid === exp_v, "base cleared early");
        chk(current_pointer === 3'h6, "base pointer step");
        exp_q.push_back(8'h20);
        ev(1, 0, 6, 0);
        exp_v[4] = 0;
        drain(0, "fifo limit");
        chk(msg_valid === exp_v, "base at limit");
        chk(current_pointer === 3'h7, "base pointer limit");
        wr(1, 1, 1, 0, 0, CMO_KIND_BASE, 1, 2, 3, 3);
        wr(2, 1, 1, 0, 0, CMO_KIND_GWSLV, 1, 0, 0, 0);
        wr(3, 1, 1, 0, 0, CMO_KIND_GWSLV, 1, 0, 0, 0);
        exp_q.push_back(8'h30);
        ev(0, 0, 2, 0);
        exp_v[2] = 0;
        exp_v[1] = 0;
        drain(0, "gateway rx");
        chk(msg_valid === exp_v, "gateway store");
        ev(1, 0, 3, 0);
        exp_v[3] = 0;
        drain(0, "gateway tx");
        chk(msg_valid === exp_v, "gateway tx");
        chk(current_pointer === 3'h2, "pointer wrap");
        wr(2, 0, 1, 0, 0, CMO_KIND_STD, 0, 0, 0, 0);
        wr(3, 1, 0, 0, 0, CMO_KIND_STD, 0, 0, 0, 0);
        wr(5, 1, 0, 0, 0, CMO_KIND_STD, 0, 0, 0, 0);
        treq(2, 0);
        drain(0, "invalid answer");
        exp_q.push_back(8'h13);
        treq(3, 0);
        drain(0, "tx start");
        exp_q.push_back(8'h13);
        exp_q.push_back(8'h15);
        treq(5, 1);
        drain(1, "retry");
        tx_done = 1;
        @(negedge clk);
        tx_done = 0;
        tx_busy = 1;
        treq(5, 0);
        tx_busy = 0;
        drain(1, "busy");
        treq(5, 0);
        drain(0, "next frame");
        wr(5, 0, 0, 0, 0, CMO_KIND_STD, 0, 0, 0, 0);
        treq(5, 1);
        drain(0, "no retry");
        counter_function_mode = CMO_COUNTER_FUNCTION_MODE_TIMING;
        measurement_select = CMO_SEL_REC_AFTER_DOM;
        seed = lfsr(seed);
        n = 12 + seed[4:0];
        repeat (4) @(negedge clk);
        other_dom = 1;
        repeat (n) @(negedge clk);
        other_dom = 0;
        repeat (6) @(negedge clk);
        chk(frame_counter_value >= n - 1 && frame_counter_value <= n + 1,
            "dominant width");
        measurement_select = CMO_SEL_DOM_LOOP;
        can_tx = 0;
        repeat (12) @(negedge clk);
        chk(frame_counter_value >= 5 && frame_counter_value <= 9,
            "dominant loop");
        measurement_select = CMO_SEL_REC_LOOP;
        can_tx = 1;
        other_dom = 1;
        repeat (8) @(negedge clk);
        other_dom = 0;
        repeat (4) @(negedge clk);
        chk(frame_counter_value >= 8 && frame_counter_value <= 12,
            "recessive loop");
        measurement_select = CMO_SEL_SYNC_SP;
        sample_point = 1;
        @(negedge clk);
        sample_point = 0;
        repeat (n - 1) @(negedge clk);
        other_dom = 1;
        repeat (6) @(negedge clk);
        chk(frame_counter_value >= n && frame_counter_value <= n + 4,
            "sync phase");
        other_dom = 0;
        sync_enable = 0;
        repeat (4) @(negedge clk);
        other_dom = 1;
        repeat (6) @(negedge clk);
        chk(frame_counter_value >= n && frame_counter_value <= n + 4,
            "unqualified edge");
        other_dom = 0;
        sync_enable = 1;
        $display("test timing done");
        close_out();
    end
endmodule : test_cmo_top
`default_nettype wire
